// [rtl/ica_bridge.sv]
// indirect core register access and process ram read window bridge
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R1 - data register carries value moved to or from the selected core register
// R2 - data right-justified in the register; bridge aligns lanes toward the core
// R3 - data read returns core data when direction is read, else last write
// R4 - writing one to busy launches one core access at target offset
// R5 - busy holds until done then self-clears; read data valid then
// R6 - writing zero to busy has no effect
// R7 - host leaves command and data registers alone while busy
// R8 - direction select zero writes, one reads; resets to zero
// R9 - access width is 1, 2 or 4 bytes only
// R10 - target offset is a 16-bit byte address in the core map
// R11 - host aligns 2-byte and 4-byte accesses
// R12 - read byte count decrements as bytes are fetched
// R13 - read start address increments as bytes are fetched
// R14 - host leaves read window alone while reading runs
// R15 - every fetched byte lies within 1000h to 2FFFh
// R16 - running flag starts fetch; self-clears when whole transfer ends
// R17 - host reads fifo only while data-available shows one
// R18 - word counter rises on fetch, drops per host word read
// R19 - reserved command bits read zero and ignore writes
// R20 - data, command and read window reset to zero

module ica_bridge
   import ica_pkg::*;
#(
   parameter int FIFO_DEPTH = ICA_FIFO_DEPTH_WORDS
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [9:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [31:0] host_wdata,
   output logic [31:0] host_rdata_q,
   output logic host_rvalid_q,
   output logic csr_req_q,
   output logic csr_we_q,
   output logic [15:0] target_register_offset_q,
   output logic [3:0] csr_be_q,
   output logic [31:0] csr_wdata_q,
   input wire logic csr_ack,
   input wire logic [31:0] csr_rdata,
   output logic pram_req_q,
   output logic [15:0] pram_addr_q,
   input wire logic pram_ack,
   input wire logic [31:0] pram_rdata,
   output logic fifo_push_q,
   output logic [31:0] fifo_data_q,
   output logic [3:0] fifo_be_q,
   output logic fifo_flush_q
);

   // ---------------------------------------------------------------
   // host access decode
   // ---------------------------------------------------------------
   logic wr_data, wr_cmd, wr_win, wr_prd, rd_fifo;

   always_comb begin
      wr_data = 1'b0;
      wr_cmd = 1'b0;
      wr_win = 1'b0;
      wr_prd = 1'b0;
      if (host_wr && host_addr == ICA_OFF_DATA) begin
         wr_data = 1'b1;
      end else if (host_wr && host_addr == ICA_OFF_CMD) begin
         wr_cmd = 1'b1;
      end else if (host_wr && host_addr == ICA_OFF_PRD_WIN) begin
         wr_win = 1'b1;
      end else if (host_wr && host_addr == ICA_OFF_PRD_CMD) begin
         wr_prd = 1'b1;
      end
      rd_fifo = host_rd && host_addr <= ICA_OFF_FIFO_LAST;
   end

   // ---------------------------------------------------------------
   // indirect core register access
   // ---------------------------------------------------------------
   ica_csr_state_e cs_q, cs_d;
   logic [31:0] wr_val_q, wr_val_d;
   logic [31:0] rd_val_q, rd_val_d;
   logic dir_q, dir_d;
   logic [2:0] size_q, size_d;
   logic [15:0] target_q, target_d;
   logic csr_req_d, csr_we_d;
   logic [15:0] target_register_offset_d;
   logic [3:0] csr_be_d;
   logic [31:0] csr_wdata_d;
   logic [31:0] lane_wdata, just_rdata;
   logic [3:0] lane_be;

   ica_lane_align u_align (
      .addr_lo(target_q[1:0]),
      .size_bytes(size_q),
      .just_wdata(wr_val_q),
      .lane_rdata(csr_rdata),
      .lane_wdata(lane_wdata),
      .byte_en(lane_be),
      .just_rdata(just_rdata)
   );

   always_comb begin
      cs_d = cs_q;
      wr_val_d = wr_val_q;
      rd_val_d = rd_val_q;
      dir_d = dir_q;
      size_d = size_q;
      target_d = target_q;
      csr_req_d = csr_req_q;
      csr_we_d = csr_we_q;
      target_register_offset_d = target_register_offset_q;
      csr_be_d = csr_be_q;
      csr_wdata_d = csr_wdata_q;
      if (wr_data) begin
         wr_val_d = host_wdata; // R1
      end
      if (wr_cmd) begin
         dir_d = host_wdata[ICA_CMD_DIR_BIT]; // R8
         size_d = host_wdata[ICA_CMD_SIZE_MSB:ICA_CMD_SIZE_LSB]; // R9
         target_d = host_wdata[ICA_CMD_ADDR_MSB:0]; // R10
      end
      case (cs_q)
         ICA_CS_IDLE: begin
            // a zero in the busy bit only updates the fields
            if (wr_cmd && host_wdata[ICA_CMD_BUSY_BIT]) begin // R4 R6
               cs_d = ICA_CS_WAIT;
               csr_req_d = 1'b1;
            end
         end
         ICA_CS_WAIT: begin
            if (csr_ack) begin
               cs_d = ICA_CS_IDLE; // R5
               csr_req_d = 1'b0;
               if (dir_q) begin
                  rd_val_d = just_rdata; // R2
               end
            end
         end
         default: cs_d = ICA_CS_IDLE;
      endcase
      // launch snapshot of the fields, refreshed every waiting cycle until the core answers
      if (cs_q == ICA_CS_WAIT && !csr_ack) begin
         csr_we_d = !dir_q; // R8
         target_register_offset_d = target_q; // R10
         csr_be_d = lane_be; // R2
         csr_wdata_d = lane_wdata; // R2
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cs_q <= ICA_CS_IDLE;
         wr_val_q <= ICA_RST_WORD; // R20
         rd_val_q <= ICA_RST_WORD;
         dir_q <= 1'b0;
         size_q <= ICA_RST_SIZE;
         target_q <= ICA_RST_HALF;
         csr_req_q <= 1'b0;
         csr_we_q <= 1'b0;
         target_register_offset_q <= ICA_RST_HALF;
         csr_be_q <= 4'h0;
         csr_wdata_q <= ICA_RST_WORD;
      end else begin
         cs_q <= cs_d;
         wr_val_q <= wr_val_d;
         rd_val_q <= rd_val_d;
         dir_q <= dir_d;
         size_q <= size_d;
         target_q <= target_d;
         csr_req_q <= csr_req_d;
         csr_we_q <= csr_we_d;
         target_register_offset_q <= target_register_offset_d;
         csr_be_q <= csr_be_d;
         csr_wdata_q <= csr_wdata_d;
      end
   end

   // ---------------------------------------------------------------
   // process ram read fetch engine
   // ---------------------------------------------------------------
   ica_prd_state_e ps_q, ps_d;
   logic run_q, run_d;
   logic [15:0] len_q, len_d;
   logic [15:0] start_q, start_d;
   logic [4:0] cnt_q, cnt_d;
   logic pram_req_d;
   logic [15:0] pram_addr_d;
   logic fifo_push_d, fifo_flush_d;
   logic [31:0] fifo_data_d;
   logic [3:0] fifo_be_d;
   logic [2:0] room, take;
   logic pop, abort;

   always_comb begin
      ps_d = ps_q;
      run_d = run_q;
      len_d = len_q;
      start_d = start_q;
      cnt_d = cnt_q;
      pram_req_d = pram_req_q;
      pram_addr_d = pram_addr_q;
      fifo_push_d = 1'b0;
      fifo_flush_d = 1'b0;
      fifo_data_d = fifo_data_q;
      fifo_be_d = fifo_be_q;
      // bytes of this fetch: up to the next word boundary or the end
      room = ICA_BYTES_PER_WORD - {1'b0, start_q[1:0]};
      take = (len_q < {13'h0000, room}) ? len_q[2:0] : room;
      abort = wr_prd && host_wdata[ICA_PRD_ABORT_BIT];
      // reads while empty are ignored by the counter
      pop = rd_fifo && cnt_q != ICA_RST_CNT; // R17
      if (pop) begin
         cnt_d = cnt_q - 5'h01; // R18
      end
      if (wr_win && !run_q) begin
         len_d = host_wdata[ICA_WIN_LEN_MSB:ICA_WIN_LEN_LSB];
         start_d = host_wdata[ICA_WIN_START_MSB:0];
      end
      if (wr_prd && host_wdata[ICA_PRD_RUN_BIT] && !run_q) begin
         run_d = 1'b1; // R16
      end
      case (ps_q)
         ICA_PS_IDLE: begin
            if (run_q && len_q == ICA_RST_HALF) begin
               run_d = 1'b0; // R16
            end else if (run_q && int'(cnt_q) < FIFO_DEPTH) begin
               ps_d = ICA_PS_WAIT;
               pram_req_d = 1'b1;
               pram_addr_d = {start_q[15:2], 2'b00};
            end
         end
         ICA_PS_WAIT: begin
            if (pram_ack) begin
               ps_d = ICA_PS_IDLE;
               pram_req_d = 1'b0;
               fifo_push_d = 1'b1;
               fifo_data_d = pram_rdata;
               fifo_be_d = 4'((ica_size_mask(take) << start_q[1:0]));
               len_d = len_q - {13'h0000, take}; // R12
               start_d = start_q + {13'h0000, take}; // R13
               cnt_d = cnt_d + 5'h01; // R18
            end
         end
         default: ps_d = ICA_PS_IDLE;
      endcase
      if (abort) begin
         ps_d = ICA_PS_IDLE;
         run_d = 1'b0;
         pram_req_d = 1'b0;
         fifo_push_d = 1'b0;
         fifo_flush_d = 1'b1;
         cnt_d = ICA_RST_CNT;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ps_q <= ICA_PS_IDLE;
         run_q <= 1'b0;
         len_q <= ICA_RST_HALF; // R20
         start_q <= ICA_RST_HALF;
         cnt_q <= ICA_RST_CNT;
         pram_req_q <= 1'b0;
         pram_addr_q <= ICA_RST_HALF;
         fifo_push_q <= 1'b0;
         fifo_flush_q <= 1'b0;
         fifo_data_q <= ICA_RST_WORD;
         fifo_be_q <= 4'h0;
      end else begin
         ps_q <= ps_d;
         run_q <= run_d;
         len_q <= len_d;
         start_q <= start_d;
         cnt_q <= cnt_d;
         pram_req_q <= pram_req_d;
         pram_addr_q <= pram_addr_d;
         fifo_push_q <= fifo_push_d;
         fifo_flush_q <= fifo_flush_d;
         fifo_data_q <= fifo_data_d;
         fifo_be_q <= fifo_be_d;
      end
   end

   // ---------------------------------------------------------------
   // host read path
   // ---------------------------------------------------------------
   logic [31:0] host_rdata_d;
   logic busy;

   always_comb begin
      busy = cs_q == ICA_CS_WAIT;
      host_rdata_d = ICA_RST_WORD;
      if (host_addr == ICA_OFF_DATA) begin
         host_rdata_d = dir_q ? rd_val_q : wr_val_q; // R3
      end else if (host_addr == ICA_OFF_CMD) begin
         host_rdata_d[ICA_CMD_BUSY_BIT] = busy; // R5
         host_rdata_d[ICA_CMD_DIR_BIT] = dir_q;
         host_rdata_d[ICA_CMD_SIZE_MSB:ICA_CMD_SIZE_LSB] = size_q; // R19
         host_rdata_d[ICA_CMD_ADDR_MSB:0] = target_q;
      end else if (host_addr == ICA_OFF_PRD_WIN) begin
         host_rdata_d = {len_q, start_q};
      end else if (host_addr == ICA_OFF_PRD_CMD) begin
         host_rdata_d[ICA_PRD_RUN_BIT] = run_q;
         host_rdata_d[ICA_PRD_CNT_MSB:ICA_PRD_CNT_LSB] = cnt_q; // R18
         host_rdata_d[ICA_PRD_AVAIL_BIT] = cnt_q != ICA_RST_CNT;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         host_rdata_q <= ICA_RST_WORD;
         host_rvalid_q <= 1'b0;
      end else begin
         host_rdata_q <= host_rdata_d;
         host_rvalid_q <= host_rd;
      end
   end

endmodule

`default_nettype wire

// [rtl/ica_lane_align.sv]
// byte lane steering between right-justified data and core lanes
`timescale 1ns/100ps
`default_nettype none

module ica_lane_align
   import ica_pkg::*;
(
   input wire logic [1:0] addr_lo,
   input wire logic [2:0] size_bytes,
   input wire logic [31:0] just_wdata,
   input wire logic [31:0] lane_rdata,
   output logic [31:0] lane_wdata,
   output logic [3:0] byte_en,
   output logic [31:0] just_rdata
);

   logic [3:0] low_mask;
   logic [31:0] bit_mask;
   logic [31:0] shifted;

   always_comb begin
      low_mask = ica_size_mask(size_bytes);
      byte_en = 4'((low_mask << addr_lo));
      lane_wdata = just_wdata << {addr_lo, 3'b000};
      shifted = lane_rdata >> {addr_lo, 3'b000};
      for (int i = 0; i < 4; i++) begin
         bit_mask[i*8 +: 8] = {8{low_mask[i]}};
      end
      just_rdata = shifted & bit_mask;
   end

endmodule

`default_nettype wire

// [rtl/ica_pkg.sv]
// constants shared by the indirect core register access bridge
package ica_pkg;

   // ---------------------------------------------------------------
   // host register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [9:0] ICA_OFF_FIFO_FIRST = 10'h000;
   localparam logic [9:0] ICA_OFF_FIFO_LAST = 10'h01C;
   localparam logic [9:0] ICA_OFF_DATA = 10'h300;
   localparam logic [9:0] ICA_OFF_CMD = 10'h304;
   localparam logic [9:0] ICA_OFF_PRD_WIN = 10'h308;
   localparam logic [9:0] ICA_OFF_PRD_CMD = 10'h30C;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int ICA_CMD_BUSY_BIT = 31;
   localparam int ICA_CMD_DIR_BIT = 30;
   localparam int ICA_CMD_SIZE_MSB = 18;
   localparam int ICA_CMD_SIZE_LSB = 16;
   localparam int ICA_CMD_ADDR_MSB = 15;
   localparam int ICA_WIN_LEN_MSB = 31;
   localparam int ICA_WIN_LEN_LSB = 16;
   localparam int ICA_WIN_START_MSB = 15;
   localparam int ICA_PRD_RUN_BIT = 31;
   localparam int ICA_PRD_ABORT_BIT = 30;
   localparam int ICA_PRD_CNT_MSB = 12;
   localparam int ICA_PRD_CNT_LSB = 8;
   localparam int ICA_PRD_AVAIL_BIT = 0;

   // ---------------------------------------------------------------
   // reset values and counts
   // ---------------------------------------------------------------
   localparam logic [31:0] ICA_RST_WORD = 32'h0000_0000;
   localparam logic [15:0] ICA_RST_HALF = 16'h0000;
   localparam logic [2:0] ICA_RST_SIZE = 3'h0;
   localparam logic [4:0] ICA_RST_CNT = 5'h00;
   localparam int ICA_FIFO_DEPTH_WORDS = 16;
   localparam logic [2:0] ICA_BYTES_PER_WORD = 3'h4;

   // ---------------------------------------------------------------
   // state machines, gray coded
   // ---------------------------------------------------------------
   typedef enum logic {
      ICA_CS_IDLE = 1'b0,
      ICA_CS_WAIT = 1'b1
   } ica_csr_state_e;

   typedef enum logic {
      ICA_PS_IDLE = 1'b0,
      ICA_PS_WAIT = 1'b1
   } ica_prd_state_e;

   // byte mask for an access of 1 to 4 bytes, low aligned
   function automatic logic [3:0] ica_size_mask(input logic [2:0] size);
      logic [3:0] m;
      m = 4'h0;
      case (size)
         3'h1: m = 4'h1;
         3'h2: m = 4'h3;
         3'h3: m = 4'h7;
         3'h4: m = 4'hF;
         default: m = 4'h0;
      endcase
      return m;
   endfunction

endpackage

// [sim/ica_bridge_properties.sv]
// port assertions for the indirect access bridge
`timescale 1ns/100ps
`default_nettype none

module ica_bridge_properties
   import ica_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [9:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [31:0] host_wdata,
   input wire logic [31:0] host_rdata_q,
   input wire logic host_rvalid_q,
   input wire logic csr_req_q,
   input wire logic csr_we_q,
   input wire logic [15:0] target_register_offset_q,
   input wire logic [3:0] csr_be_q,
   input wire logic csr_ack,
   input wire logic pram_req_q,
   input wire logic pram_ack,
   input wire logic fifo_push_q,
   input wire logic fifo_flush_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic launch;
   assign launch = host_wr && host_addr == ICA_OFF_CMD && host_wdata[31]
                   && !csr_req_q;

   function automatic logic [3:0] lanes(input logic [2:0] s,
                                        input logic [1:0] a);
      logic [3:0] m;
      m = (s == 3'h1) ? 4'h1 : (s == 3'h2) ? 4'h3 : (s == 3'h4) ? 4'hF : 4'h0;
      return m << a;
   endfunction

   property p_launch;
      launch |=> csr_req_q ##1 (csr_we_q != $past(host_wdata[30], 2));
   endproperty
   a_launch: assert property (p_launch) else $error("bad launch");

   property p_target;
      launch |-> ##2 target_register_offset_q == $past(host_wdata[15:0], 2) && csr_be_q ==
         lanes($past(host_wdata[18:16], 2), $past(host_wdata[1:0], 2));
   endproperty
   a_target: assert property (p_target) else $error("bad target");

   property p_hold;
      csr_req_q && !csr_ack |=> csr_req_q;
   endproperty
   a_hold: assert property (p_hold) else $error("req dropped");

   property p_clear;
      csr_ack |=> !csr_req_q;
   endproperty
   a_clear: assert property (p_clear) else $error("req stuck");

   property p_zero;
      host_wr && host_addr == ICA_OFF_CMD && !host_wdata[31] && !csr_req_q
         |=> !csr_req_q;
   endproperty
   a_zero: assert property (p_zero) else $error("zero launched");

   property p_busy_rd;
      host_rd && host_addr == ICA_OFF_CMD |=> host_rvalid_q &&
         host_rdata_q[31] == $past(csr_req_q) && host_rdata_q[29:19] == 11'h0;
   endproperty
   a_busy_rd: assert property (p_busy_rd) else $error("bad cmd read");

   property p_fetch;
      pram_ack |=> !pram_req_q && fifo_push_q;
   endproperty
   a_fetch: assert property (p_fetch) else $error("bad fetch end");

   property p_push;
      fifo_push_q |-> $past(pram_ack);
   endproperty
   a_push: assert property (p_push) else $error("stray push");

   property p_fetch_hold;
      pram_req_q && !pram_ack |=> pram_req_q;
   endproperty
   a_fetch_hold: assert property (p_fetch_hold) else $error("fetch drop");

   c_csr: cover property (csr_ack);
   c_push: cover property (fifo_push_q);
   c_flush: cover property (fifo_flush_q);
endmodule

bind ica_bridge ica_bridge_properties #(.FIFO_DEPTH(FIFO_DEPTH))
   ica_bridge_properties_i (.clk, .rst, .host_addr, .host_wr, .host_rd,
   .host_wdata, .host_rdata_q, .host_rvalid_q, .csr_req_q, .csr_we_q,
   .target_register_offset_q, .csr_be_q, .csr_ack, .pram_req_q, .pram_ack, .fifo_push_q,
   .fifo_flush_q);

`default_nettype wire

// [sim/ica_core_model.sv]
// core register and process ram model with set answer delays
`timescale 1ns/100ps
`default_nettype none

module ica_core_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] cdly,
   input wire logic [3:0] pdly,
   input wire logic csr_req_q,
   input wire logic csr_we_q,
   input wire logic [15:0] target_register_offset_q,
   input wire logic [3:0] csr_be_q,
   input wire logic [31:0] csr_wdata_q,
   output logic csr_ack,
   output logic [31:0] csr_rdata,
   input wire logic pram_req_q,
   input wire logic [15:0] pram_addr_q,
   output logic pram_ack,
   output logic [31:0] pram_rdata
);
   logic [31:0] mem [4];
   logic [31:0] last;
   logic [3:0] cc, pc;
   logic [7:0] a;
   logic [31:0] pat;
   assign a = pram_addr_q[7:0];
   assign pat = {a + 8'h03, a + 8'h02, a + 8'h01, a};
   // idle buses show inverted data, never a stale match
   assign csr_rdata = csr_ack ? last : ~last;
   assign pram_rdata = pram_ack ? pat : ~pat;

   always_ff @(posedge clk) begin
      csr_ack <= 1'b0;
      pram_ack <= 1'b0;
      if (rst) begin
         cc <= 4'h0;
         pc <= 4'h0;
         last <= 32'h0000_0000;
         for (int i = 0; i < 4; i++) mem[i] <= 32'h0000_0000;
      end else begin
         if (csr_req_q && !csr_ack) begin
            cc <= cc + 4'h1;
            // answers in the first request cycle only when cdly is zero
            if (cc >= cdly) begin
               csr_ack <= 1'b1;
               cc <= 4'h0;
               last <= mem[target_register_offset_q[3:2]];
               for (int i = 0; i < 4; i++) begin
                  if (csr_we_q && csr_be_q[i]) begin
                     mem[target_register_offset_q[3:2]][8*i+:8] <= csr_wdata_q[8*i+:8];
                  end
               end
            end
         end
         if (pram_req_q && !pram_ack) begin
            pc <= pc + 4'h1;
            if (pc >= pdly) begin
               pram_ack <= 1'b1;
               pc <= 4'h0;
            end
         end
      end
   end
endmodule

`default_nettype wire

// [sim/indirect_core_register_access_tb_top.sv]
// self-checking bench for the indirect access bridge
`timescale 1ns/100ps
`default_nettype none

module indirect_core_register_access_tb_top
   import ica_pkg::*;
;
   localparam int DEPTH = 4;
   typedef struct packed {
      logic dir;
      logic [2:0] sz;
      logic [15:0] ad;
      logic [31:0] v;
   } ica_row_s;
   logic clk = 1'b0, rst = 1'b1, host_wr = 1'b0, host_rd = 1'b0;
   logic [9:0] host_addr = 10'h000;
   logic [31:0] host_wdata = 32'h0000_0000, host_rdata_q, csr_wdata_q;
   logic [31:0] csr_rdata;
   // be and data of the first 8 words handed to the read fifo
   logic [35:0] pushes [8];
   int n_push = 0, n_flush = 0;
   logic [31:0] pram_rdata, fifo_data_q;
   logic host_rvalid_q, csr_req_q, csr_we_q, csr_ack, pram_req_q, pram_ack;
   logic fifo_push_q, fifo_flush_q;
   logic [15:0] target_register_offset_q, pram_addr_q;
   logic [3:0] csr_be_q, fifo_be_q, cdly = 4'h1, pdly = 4'h1;
   int n_fail = 0, checks_done = 0, cyc = 0;
   ica_row_s rows [7] = '{
      '{1'b0, 3'h4, 16'h0010, 32'h1234_5678},
      '{1'b0, 3'h1, 16'h0011, 32'h0000_00AB},
      '{1'b0, 3'h2, 16'h0012, 32'h0000_CDEF},
      '{1'b1, 3'h4, 16'h0010, 32'hCDEF_AB78},
      '{1'b1, 3'h1, 16'h0013, 32'h0000_00CD},
      '{1'b1, 3'h2, 16'h0010, 32'h0000_AB78},
      '{1'b1, 3'h1, 16'h0011, 32'h0000_00AB}};

   ica_bridge #(.FIFO_DEPTH(DEPTH)) ica_bridge_i (.*);
   ica_core_model ica_core_model_i (.*);

   always #2 clk = ~clk;

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask

   task automatic hw(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      #1 {host_wr, host_addr, host_wdata} = {1'b1, a, d};
      @(posedge clk);
      #1 host_wr = 1'b0;
   endtask

   task automatic hr(input logic [9:0] a, output logic [31:0] d);
      @(posedge clk);
      #1 {host_rd, host_addr} = {1'b1, a};
      @(posedge clk);
      #1 host_rd = 1'b0;
      d = host_rdata_q;
      chk({31'h0, host_rvalid_q}, 32'h0000_0001);
   endtask

   // poll until the self-clearing bit 31 drops
   task automatic idle(input logic [9:0] a);
      logic [31:0] r;
      for (int k = 0; k < 64; k++) begin
         hr(a, r);
         if (r[31] === 1'b0) break;
      end
      chk({31'h0, r[31]}, 32'h0000_0000);
   endtask

   task results;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      if (fifo_push_q) begin
         if (n_push < 8) pushes[n_push] = {fifo_be_q, fifo_data_q};
         n_push++;
      end
      if (fifo_flush_q) n_flush++;
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         results;
      end
   end

   initial begin
      logic [31:0] v;
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      hr(ICA_OFF_DATA, v);
      chk(v, 32'h0000_0000);
      hr(ICA_OFF_CMD, v);
      chk(v, 32'h0000_0000);
      hr(ICA_OFF_PRD_WIN, v);
      chk(v, 32'h0000_0000);
      hr(10'h3F0, v);
      chk(v, 32'h0000_0000);
      $display("reset test done");
      // host keeps data and command still while busy, legal sizes only
      foreach (rows[i]) begin
         cdly = 4'(i % 3 + 1);
         if (!rows[i].dir) hw(ICA_OFF_DATA, rows[i].v);
         hw(ICA_OFF_CMD, {1'b1, rows[i].dir, 11'h0, rows[i].sz,
            rows[i].ad});
         idle(ICA_OFF_CMD);
         hr(ICA_OFF_DATA, v);
         chk(v, rows[i].v);
         $display("row %0d done", i);
      end
      hw(ICA_OFF_CMD, 32'h7FF8_0010);
      hr(ICA_OFF_CMD, v);
      chk(v, 32'h4000_0010);
      $display("zero busy test done");
      // window stays inside the process ram and is not touched while running
      pdly = 4'h2;
      hw(ICA_OFF_PRD_WIN, 32'h0005_1001);
      hw(ICA_OFF_PRD_CMD, 32'h8000_0000);
      idle(ICA_OFF_PRD_CMD);
      hr(ICA_OFF_PRD_WIN, v);
      chk(v, 32'h0000_1006);
      hr(ICA_OFF_PRD_CMD, v);
      chk(v, 32'h0000_0201);
      chk(32'(n_push), 32'h0000_0002);
      chk({28'h0, pushes[0][35:32]}, 32'h0000_000E);
      chk(pushes[0][31:0], 32'h0302_0100);
      chk({28'h0, pushes[1][35:32]}, 32'h0000_0003);
      chk(pushes[1][31:0], 32'h0706_0504);
      hr(ICA_OFF_FIFO_FIRST, v);
      hr(ICA_OFF_FIFO_LAST, v);
      hr(ICA_OFF_PRD_CMD, v);
      chk(v, 32'h0000_0000);
      $display("fetch test done");
      pdly = 4'h1;
      hw(ICA_OFF_PRD_WIN, 32'h0040_2000);
      hw(ICA_OFF_PRD_CMD, 32'h8000_0000);
      repeat (60) @(posedge clk);
      hr(ICA_OFF_PRD_CMD, v);
      chk(v, 32'h8000_0001 | (32'(DEPTH) << 8));
      hr(ICA_OFF_PRD_WIN, v);
      chk(v, 32'h0040_2000 - (32'(DEPTH) * 32'h0000_0004) *
         32'h0000_FFFF);
      chk(32'(n_push), 32'(2 + DEPTH));
      chk({28'h0, pushes[5][35:32]}, 32'h0000_000F);
      chk(pushes[5][31:0], 32'h0F0E_0D0C);
      hw(ICA_OFF_PRD_CMD, 32'h4000_0000);
      hr(ICA_OFF_PRD_CMD, v);
      chk(v, 32'h0000_0000);
      chk(32'(n_flush), 32'h0000_0001);
      $display("depth and abort test done");
      cdly = 4'h8;
      hw(ICA_OFF_CMD, 32'hC004_0010);
      @(posedge clk);
      #1 rst = 1'b1;
      @(posedge clk);
      #1 rst = 1'b0;
      hr(ICA_OFF_CMD, v);
      chk(v, 32'h0000_0000);
      $display("mid reset test done");
      results;
   end
endmodule

`default_nettype wire
